// ==== rtl/bfd_pkg.sv ====
// Shared opcodes, field positions, flag bits and reset values for the decoder
package bfd_pkg;
	// Instruction word and field layout
	localparam int BFD_IW = 12;
	localparam int BFD_ADDR_W = 5;
	localparam int BFD_DEST_BIT = 5;
	localparam int BFD_BIT_LSB = 5;
	localparam int BFD_FILE_DEPTH = 32;
	// Upper six bits of byte-file opcodes
	localparam logic [5:0] BFD_OP_OR_FILE = 6'h04;
	localparam logic [5:0] BFD_OP_AND_FILE = 6'h05;
	localparam logic [5:0] BFD_OP_ADD_FILE = 6'h07;
	localparam logic [5:0] BFD_OP_DEC_FILE = 6'h03;
	localparam logic [5:0] BFD_OP_MOVE_FILE = 6'h08;
	localparam logic [5:0] BFD_OP_INV_FILE = 6'h09;
	localparam logic [5:0] BFD_OP_DEC_SKIP = 6'h0b;
	// Upper four bits of bit and literal opcodes
	localparam logic [3:0] BFD_OP_CLR_BIT = 4'h4;
	localparam logic [3:0] BFD_OP_LOAD_LIT = 4'hc;
	localparam logic [3:0] BFD_OP_OR_LIT = 4'hd;
	localparam logic [3:0] BFD_OP_AND_LIT = 4'he;
	// Status flag positions in flags output
	localparam int BFD_FLAG_C = 0;
	localparam int BFD_FLAG_DC = 1;
	localparam int BFD_FLAG_Z = 2;
	// Reset values
	localparam logic [7:0] BFD_ACC_RST = 8'h00;
	localparam logic [2:0] BFD_FLAGS_RST = 3'h0;
	localparam logic [7:0] BFD_FILE_RST = 8'h00;
	// State encoding
	typedef enum logic [1:0] {
		BFD_ST_EXEC = 2'b01,
		BFD_ST_SKIP = 2'b10
	} bfd_state_t;
endpackage

// ==== rtl/bfd_alu.sv ====
// Combinational datapath computing result and flags for one instruction
`timescale 1ns/1ps
module bfd_alu
	import bfd_pkg::*;
(
	input wire logic [11:0] instr,
	input wire logic [7:0] acc,
	input wire logic [7:0] file_val,
	input wire logic [2:0] flags_in,
	output logic [7:0] result,
	output logic [2:0] flags_out,
	output logic to_file,
	output logic write_en,
	output logic skip_req,
	output logic known
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] lit;
	logic dest;
	assign sum = {1'b0, acc} + {1'b0, file_val};
	assign low_sum = {1'b0, acc[3:0]} + {1'b0, file_val[3:0]};
	assign lit = instr[7:0];
	assign dest = instr[BFD_DEST_BIT];

	// Decode, compute result, route it and update flags
	always_comb
	begin
		result = 8'h00;
		flags_out = flags_in;
		to_file = dest;
		write_en = 1'b1;
		skip_req = 1'b0;
		known = 1'b1;
		if (instr[11:8] == BFD_OP_CLR_BIT)
		begin
			result = file_val & ~(8'h01 << instr[7:5]);
			to_file = 1'b1;
		end
		else if (instr[11:8] == BFD_OP_AND_LIT)
		begin
			result = acc & lit;
			to_file = 1'b0;
			flags_out[BFD_FLAG_Z] = (result == 8'h00);
		end
		else if (instr[11:8] == BFD_OP_OR_LIT)
		begin
			result = acc | lit;
			to_file = 1'b0;
			flags_out[BFD_FLAG_Z] = (result == 8'h00);
		end
		else if (instr[11:8] == BFD_OP_LOAD_LIT)
		begin
			result = lit;
			to_file = 1'b0;
		end
		else
		begin
			unique case (instr[11:6])
				BFD_OP_AND_FILE: result = acc & file_val;
				BFD_OP_OR_FILE: result = acc | file_val;
				BFD_OP_DEC_FILE: result = file_val - 8'h01;
				BFD_OP_MOVE_FILE: result = file_val;
				BFD_OP_INV_FILE: result = ~file_val;
				BFD_OP_DEC_SKIP: result = file_val - 8'h01;
				BFD_OP_ADD_FILE:
				begin
					result = sum[7:0];
					flags_out[BFD_FLAG_C] = sum[8];
					flags_out[BFD_FLAG_DC] = low_sum[4];
				end
				default:
				begin
					known = 1'b0;
					write_en = 1'b0;
				end
			endcase
			if (known && instr[11:6] != BFD_OP_DEC_SKIP)
				flags_out[BFD_FLAG_Z] = (result == 8'h00);
			skip_req = (instr[11:6] == BFD_OP_DEC_SKIP)
				&& (result == 8'h00);
		end
	end
endmodule // bfd_alu

// ==== rtl/bfd_decoder.sv ====
// Byte-file and literal instruction executor with 32-entry file space
`timescale 1ns/1ps
module bfd_decoder
	import bfd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	output logic instr_ready,
	output logic [7:0] acc_out,
	output logic [2:0] flags,
	output logic skip_out,
	output logic illegal_out,
	input wire logic [4:0] peek_addr,
	output logic [7:0] peek_data
);
	typedef struct packed {
		bfd_state_t state;
		logic [7:0] acc;
		logic [2:0] flags;
		logic skip;
		logic illegal;
		logic [7:0] peek;
	} bfd_regs_t;

	bfd_regs_t r_q;
	bfd_regs_t r_d;
	logic [7:0] file_q [BFD_FILE_DEPTH];
	logic [4:0] addr;
	logic [7:0] result;
	logic [2:0] alu_flags;
	logic to_file;
	logic write_en;
	logic skip_req;
	logic known;
	logic exec;

	assign addr = instr[BFD_ADDR_W-1:0];
	assign exec = instr_valid && r_q.state == BFD_ST_EXEC;
	// Ready unless the prefetched word is being discarded
	assign instr_ready = (r_q.state == BFD_ST_EXEC);
	assign acc_out = r_q.acc;
	assign flags = r_q.flags;
	assign skip_out = r_q.skip;
	assign illegal_out = r_q.illegal;
	assign peek_data = r_q.peek;

	bfd_alu u_alu (
		.instr(instr),
		.acc(r_q.acc),
		.file_val(file_q[addr]),
		.flags_in(r_q.flags),
		.result(result),
		.flags_out(alu_flags),
		.to_file(to_file),
		.write_en(write_en),
		.skip_req(skip_req),
		.known(known)
	);

	// Next-state: execute, or swallow one word as a no-op after skip
	always_comb
	begin
		r_d = r_q;
		r_d.skip = 1'b0;
		r_d.illegal = 1'b0;
		r_d.peek = file_q[peek_addr];
		unique case (r_q.state)
			BFD_ST_EXEC:
			begin
				if (instr_valid)
				begin
					r_d.flags = alu_flags;
					r_d.illegal = !known;
					if (write_en && !to_file)
						r_d.acc = result;
					if (skip_req)
					begin
						r_d.state = BFD_ST_SKIP;
						r_d.skip = 1'b1;
					end
				end
			end
			BFD_ST_SKIP:
			begin
				if (instr_valid)
					r_d.state = BFD_ST_EXEC;
			end
			default: r_d.state = BFD_ST_EXEC;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			r_q.state <= BFD_ST_EXEC;
			r_q.acc <= BFD_ACC_RST;
			r_q.flags <= BFD_FLAGS_RST;
			r_q.skip <= 1'b0;
			r_q.illegal <= 1'b0;
			r_q.peek <= BFD_FILE_RST;
		end
		else
			r_q <= r_d;
	end

	// File register array with write-back
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < BFD_FILE_DEPTH; i++)
				file_q[i] <= BFD_FILE_RST;
		end
		else if (exec && write_en && to_file)
			file_q[addr] <= result;
	end

	logic [7:0] f_old;
	assign f_old = file_q[addr];

	// Properties share the core clock and drop out during reset
	default clocking cb_core @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_and_lit_result: assert property (
		exec && instr[11:8] == BFD_OP_AND_LIT |=>
		acc_out == ($past(r_q.acc) & $past(instr[7:0])))
		else $error("and literal result wrong");
	chk_or_lit_result: assert property (
		exec && instr[11:8] == BFD_OP_OR_LIT |=>
		acc_out == ($past(r_q.acc) | $past(instr[7:0]))
		&& flags[BFD_FLAG_Z] == (acc_out == 8'h00))
		else $error("or literal result wrong");
	chk_clr_bit_flags: assert property (
		exec && instr[11:8] == BFD_OP_CLR_BIT |=> $stable(flags))
		else $error("bit clear altered flags");
	chk_dec_skip_flags: assert property (
		exec && instr[11:6] == BFD_OP_DEC_SKIP |=> $stable(flags))
		else $error("decrement skip altered flags");
	sequence s_dec_skip_zero;
		exec && instr[11:6] == BFD_OP_DEC_SKIP && f_old == 8'h01;
	endsequence
	sequence s_swallow;
		skip_out && !instr_ready ##1 instr_ready;
	endsequence
	// The prefetched word arrives one cycle on and is swallowed
	chk_skip_two_cycle: assert property (
		s_dec_skip_zero ##1 instr_valid |-> s_swallow)
		else $error("skip did not discard next word");
	chk_dest_acc: assert property (
		exec && instr[11:6] == BFD_OP_DEC_FILE && !instr[BFD_DEST_BIT] |=>
		acc_out == $past(f_old) - 8'h01
		&& flags[BFD_FLAG_Z] == (acc_out == 8'h00))
		else $error("decrement to accumulator wrong");
	chk_and_file_flags: assert property (
		exec && instr[11:6] == BFD_OP_AND_FILE |=>
		flags[1:0] == $past(flags[1:0]))
		else $error("and file touched carry flags");
	chk_load_lit: assert property (
		exec && instr[11:8] == BFD_OP_LOAD_LIT |=>
		acc_out == $past(instr[7:0]) && $stable(flags))
		else $error("load literal wrong");
	chk_add_carry: assert property (
		exec && instr[11:6] == BFD_OP_ADD_FILE |=>
		flags[BFD_FLAG_C] ==
		({1'b0, $past(r_q.acc)} + {1'b0, $past(f_old)} > 9'h0ff))
		else $error("add carry wrong");
	chk_move_zero: assert property (
		exec && instr[11:6] == BFD_OP_MOVE_FILE |=>
		flags[BFD_FLAG_Z] == ($past(f_old) == 8'h00))
		else $error("move zero flag wrong");
	chk_or_file_zero: assert property (
		exec && instr[11:6] == BFD_OP_OR_FILE |=>
		flags[BFD_FLAG_Z] == (($past(r_q.acc) | $past(f_old)) == 8'h00))
		else $error("or file zero wrong");
	chk_dec_zero: assert property (
		exec && instr[11:6] == BFD_OP_DEC_FILE |=>
		flags[BFD_FLAG_Z] == ($past(f_old) == 8'h01))
		else $error("decrement zero wrong");
	// Write-back, remaining flags, the untaken skip and the undecoded case
	chk_clr_bit_file: assert property (
		exec && instr[11:8] == BFD_OP_CLR_BIT |=>
		file_q[$past(addr)] ==
		($past(f_old) & ~(8'h01 << $past(instr[7:5]))))
		else $error("bit clear result wrong");
	chk_add_to_file: assert property (
		exec && instr[11:6] == BFD_OP_ADD_FILE && instr[BFD_DEST_BIT] |=>
		$stable(acc_out)
		&& file_q[$past(addr)] == $past(r_q.acc) + $past(f_old))
		else $error("add to file wrong");
	chk_and_file_zero: assert property (
		exec && instr[11:6] == BFD_OP_AND_FILE |=>
		flags[BFD_FLAG_Z] == (($past(r_q.acc) & $past(f_old)) == 8'h00))
		else $error("and file zero wrong");
	chk_and_lit_zero: assert property (
		exec && instr[11:8] == BFD_OP_AND_LIT |=>
		flags[BFD_FLAG_Z] == (acc_out == 8'h00)
		&& flags[1:0] == $past(flags[1:0]))
		else $error("and literal flags wrong");
	chk_dec_skip_dest: assert property (
		exec && instr[11:6] == BFD_OP_DEC_SKIP && !instr[BFD_DEST_BIT] |=>
		acc_out == $past(f_old) - 8'h01)
		else $error("decrement skip to accumulator wrong");
	chk_skip_nonzero: assert property (
		exec && instr[11:6] == BFD_OP_DEC_SKIP && f_old != 8'h01 |=>
		instr_ready && !skip_out)
		else $error("skip taken on nonzero result");
	chk_inv_zero: assert property (
		exec && instr[11:6] == BFD_OP_INV_FILE |=>
		flags[BFD_FLAG_Z] == ($past(f_old) == 8'hff))
		else $error("invert zero flag wrong");
	chk_illegal_quiet: assert property (
		exec && !known |=>
		illegal_out && $stable(acc_out) && $stable(flags))
		else $error("undecoded word had an effect");
endmodule // bfd_decoder

// ==== sim/bfd_prog_mem.sv ====
// Program memory model feeding instruction words to the decoder
`timescale 1ns/1ps
module bfd_prog_mem
	import bfd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic instr_ready,
	input wire logic skip_out,
	output logic instr_valid,
	output logic [11:0] instr
);
	logic [11:0] rom[$];
	// Idle bus at time zero
	initial
	begin
		instr_valid = 1'b0;
		instr = 12'h000;
	end
	// Drop the taken or discarded word, then present the next one
	always @(posedge ref_clk)
	begin
		if (instr_valid && (instr_ready || skip_out))
			void'(rom.pop_front());
		#1;
		instr_valid = reset_n && (rom.size() != 0);
		instr = instr_valid ? rom[0] : ~instr; // Released bus toggles
	end
endmodule // bfd_prog_mem

// ==== sim/byte_file_alu_op_decoder_bench.sv ====
// Self-checking bench for the byte-file and literal decoder
`timescale 1ns/1ps
module byte_file_alu_op_decoder_bench
	import bfd_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] peek_addr = 5'h00;
	logic instr_valid, instr_ready, skip_out, illegal_out;
	logic [11:0] instr;
	logic [7:0] acc_out, peek_data;
	logic [2:0] flags;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_skip = 0;
	int n_illegal = 0;
	bfd_decoder dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
		.instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .acc_out(acc_out), .flags(flags),
		.skip_out(skip_out), .illegal_out(illegal_out),
		.peek_addr(peek_addr), .peek_data(peek_data));
	bfd_prog_mem mem_u (.ref_clk(ref_clk), .reset_n(reset_n),
		.instr_ready(instr_ready), .skip_out(skip_out),
		.instr_valid(instr_valid), .instr(instr));
	// Clock and pulse counts
	initial forever #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (skip_out === 1'b1) n_skip++;
	always @(posedge ref_clk) if (illegal_out === 1'b1) n_illegal++;
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Wait for the program to drain and its last result to land
	task automatic go();
		repeat (50) if (mem_u.rom.size() != 0) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	task automatic peek(input logic [4:0] a, input logic [7:0] exp);
		peek_addr = a;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("file", peek_data, exp);
	endtask
	task automatic state(input logic [7:0] a, input logic [2:0] f);
		chk("acc", acc_out, a);
		chk("flags", {5'h00, flags}, {5'h00, f});
	endtask
	// Add with carry out, digit carry and zero; load keeps flags
	task automatic t_add();
		mem_u.rom = '{12'hc17, 12'h1e2, 12'hce9, 12'h1c2, 12'hc5a};
		go();
		state(8'h5a, 3'h7);
		peek(5'h02, 8'h17);
	endtask
	// File and literal logic ops, then move
	task automatic t_logic();
		mem_u.rom = '{12'hc91, 12'h122, 12'h142, 12'he5f, 12'hd35};
		go();
		state(8'h35, 3'h3);
		peek(5'h02, 8'h97);
		mem_u.rom = '{12'he00};
		go();
		state(8'h00, 3'h7);
		mem_u.rom = '{12'h202};
		go();
		state(8'h97, 3'h3);
	endtask
	// Bit clear, decrement and invert
	task automatic t_bits();
		mem_u.rom = '{12'h4e2, 12'h0e4};
		go();
		chk("flags", {5'h00, flags}, 8'h03);
		mem_u.rom = '{12'h244};
		go();
		state(8'h00, 3'h7);
		peek(5'h02, 8'h17);
		peek(5'h04, 8'hff);
	endtask
	// Decrement and skip, with and without a zero result
	task automatic t_skip();
		mem_u.rom = '{12'hc01, 12'h1e5, 12'h2e5, 12'hc77, 12'hc33};
		go();
		state(8'h33, 3'h0);
		chk("skips", n_skip[7:0], 8'h01);
		peek(5'h05, 8'h00);
		mem_u.rom = '{12'h2c4, 12'hd01};
		go();
		state(8'hff, 3'h0);
		chk("skips", n_skip[7:0], 8'h01);
	endtask
	// Undecoded word does nothing, decrement lands in accumulator
	task automatic t_misc();
		mem_u.rom = '{12'h000};
		go();
		state(8'hff, 3'h0);
		chk("illegal", n_illegal[7:0], 8'h01);
		mem_u.rom = '{12'h0c2};
		go();
		state(8'h16, 3'h0);
		peek(5'h02, 8'h17);
	endtask
	// Reset in mid-run clears state, then execution resumes
	task automatic t_reset();
		reset_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		state(8'h00, 3'h0);
		chk("ready", {7'h00, instr_ready}, 8'h01);
		peek(5'h02, 8'h00);
		mem_u.rom = '{12'hc42};
		go();
		state(8'h42, 3'h0);
	endtask
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog against a hung program
	initial
	begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		@(posedge ref_clk);
		t_add();
		t_logic();
		t_bits();
		t_skip();
		t_misc();
		t_reset();
		tally_and_finish();
	end
endmodule // byte_file_alu_op_decoder_bench
